// *** tdc_config_register_bank.sv ***
// Top of the configuration register bank with its AXI4-Lite slave.
`default_nettype none
module tdc_config_register_bank (
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic      [1:0]  S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic      [31:0] S_AXI_RDATA,
   output logic      [1:0]  S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        ALU_DONE,
   input  wire logic        HITS_DONE,
   input  wire logic        TIMEOUT,
   output logic             IRQ,
   output logic             FORCE_ERR_VALUE,
   output logic             TEMP_CYCLE_CLOCK_SELECT,
   output logic      [7:0]  CYCLE_CLK_FAST_PERIODS,
   output logic      [2:0]  DUMMY_COUNT,
   output logic      [8:0]  TEMP_CYCLE_TIME_US,
   output logic             TEMP_FOUR_PORTS,
   output logic             FAST_OSC_ENABLE,
   output logic      [10:0] FAST_OSC_SETTLE_US,
   output logic      [2:0]  FAST_CLOCK_PREDIVIDER,
   output logic      [4:0]  RESONATOR_CAL_LENGTH,
   output logic      [4:0]  FIRE_DIVIDE,
   output logic      [3:0]  PULSE_COUNT,
   output logic             FIRE_ENABLE,
   output logic      [2:0]  EXPECTED_HITS_CH1,
   output logic      [2:0]  EXPECTED_HITS_CH2,
   output logic             CH1_ENABLE,
   output logic             CH2_ENABLE,
   output logic      [3:0]  ALU_OPERAND_A,
   output logic      [3:0]  ALU_OPERAND_B,
   output logic      [18:0] WINDOW_DELAY_FIRST,
   output logic      [18:0] WINDOW_DELAY_SECOND,
   output logic      [18:0] WINDOW_DELAY_THIRD,
   output logic             EDGE_MODE_CH1,
   output logic             EDGE_MODE_CH2,
   output logic      [1:0]  LONG_RANGE_TIMEOUT_SELECT,
   output logic             FAST_INIT_ENABLE,
   output logic      [15:0] PHASE_INVERT,
   output logic      [2:0]  FIRE_REPEAT,
   output logic             PHASE_SHIFT_DISABLE,
   output logic             START_NOISE_ENABLE,
   output logic             FIRE1_DISABLE,
   output logic             FIRE2_DISABLE,
   output logic             FIRE2_INVERT
);
   // ************************************************************
   // Storage.
   // ************************************************************
   logic [23:0] cfg [tdc_cfg_pkg::REG_COUNT];
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_fire;
   logic        wr_hit;
   logic [2:0]  wr_index;

   // Maps a byte address to a register index; 7 means unmapped.
   function automatic logic [2:0] reg_index(input logic [7:0] a);
      unique case (a)
         tdc_cfg_pkg::ADDR_CFG0: reg_index = 3'h0;
         tdc_cfg_pkg::ADDR_CFG1: reg_index = 3'h1;
         tdc_cfg_pkg::ADDR_CFG2: reg_index = 3'h2;
         tdc_cfg_pkg::ADDR_CFG3: reg_index = 3'h3;
         tdc_cfg_pkg::ADDR_CFG4: reg_index = 3'h4;
         tdc_cfg_pkg::ADDR_CFG5: reg_index = 3'h5;
         default:                reg_index = 3'h7;
      endcase
   endfunction

   // ************************************************************
   // Write channel.
   // ************************************************************
   // Address and data are caught in either order and held until both
   // are in; the response then stalls further writes until accepted.
   assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
   assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
   assign wr_fire  = aw_held && w_held && !S_AXI_BVALID;
   assign wr_index = reg_index(aw_addr);
   assign wr_hit   = wr_index != 3'h7;

   // Capture of address.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_held <= 1'b1;
         aw_addr <= S_AXI_AWADDR;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   // Capture of data.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_held <= 1'b1;
         w_data <= S_AXI_WDATA;
         w_strb <= S_AXI_WSTRB;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // Write response; unmapped addresses answer with a slave error.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= tdc_cfg_pkg::AXI_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= wr_hit ? tdc_cfg_pkg::AXI_OKAY :
                                  tdc_cfg_pkg::AXI_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // Registers change only when a whole write lands, byte lanes honoured.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cfg[0] <= tdc_cfg_pkg::RST_CFG0; // RULE_23
         cfg[1] <= tdc_cfg_pkg::RST_CFG1; // RULE_23
         cfg[2] <= tdc_cfg_pkg::RST_CFG2; // RULE_23
         cfg[3] <= tdc_cfg_pkg::RST_CFG3; // RULE_23
         cfg[4] <= tdc_cfg_pkg::RST_CFG4; // RULE_23
         cfg[5] <= tdc_cfg_pkg::RST_CFG5; // RULE_23
      end else if (wr_fire && wr_hit) begin // RULE_25
         for (int b = 0; b < 3; b++) begin
            if (w_strb[b]) begin
               cfg[wr_index][b*8 +: 8] <= w_data[b*8 +: 8];
            end
         end
      end
   end

   // ************************************************************
   // Read channel.
   // ************************************************************
   // Configuration is write-only; only the echo byte is readable.
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h00000000;
         S_AXI_RRESP  <= tdc_cfg_pkg::AXI_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         if (S_AXI_ARADDR == tdc_cfg_pkg::ADDR_ECHO) begin
            S_AXI_RDATA <= {24'h000000, cfg[1][23:16]}; // RULE_24
            S_AXI_RRESP <= tdc_cfg_pkg::AXI_OKAY;
         end else begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= tdc_cfg_pkg::AXI_SLVERR;
         end
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ************************************************************
   // Decoded and raw control outputs.
   // ************************************************************
   tdc_cfg_decode u_decode (
      .cfg0                   (cfg[0]),
      .cfg3                   (cfg[3]),
      .dummy_count            (DUMMY_COUNT),
      .cycle_time_us          (TEMP_CYCLE_TIME_US),
      .prediv_factor          (FAST_CLOCK_PREDIVIDER),
      .cal_periods            (RESONATOR_CAL_LENGTH),
      .fire_divide            (FIRE_DIVIDE),
      .settle_us              (FAST_OSC_SETTLE_US),
      .osc_enable             (FAST_OSC_ENABLE),
      .cycle_clk_fast_periods (CYCLE_CLK_FAST_PERIODS)
   );

   // Raw fields straight from the registers, so they are static.
   assign TEMP_CYCLE_CLOCK_SELECT = cfg[0][tdc_cfg_pkg::POS_CYC_CLK]; // RULE_01
   assign TEMP_FOUR_PORTS = cfg[0][tdc_cfg_pkg::POS_PORTS]; // RULE_04
   assign PULSE_COUNT = cfg[0][tdc_cfg_pkg::POS_FCNT +: 4]; // RULE_09
   assign FIRE_ENABLE = PULSE_COUNT != 4'h0; // RULE_09
   assign EXPECTED_HITS_CH1 = cfg[1][tdc_cfg_pkg::POS_HITS1 +: 3]; // RULE_10
   assign EXPECTED_HITS_CH2 = cfg[1][tdc_cfg_pkg::POS_HITS2 +: 3]; // RULE_10
   assign CH1_ENABLE = EXPECTED_HITS_CH1 != 3'h0; // RULE_10
   assign CH2_ENABLE = EXPECTED_HITS_CH2 != 3'h0; // RULE_10
   // The ALU reads operands as selector codes; a minus b in short range.
   assign ALU_OPERAND_A = cfg[1][tdc_cfg_pkg::POS_OPA +: 4]; // RULE_11
   assign ALU_OPERAND_B = cfg[1][tdc_cfg_pkg::POS_OPB +: 4]; // RULE_11
   assign WINDOW_DELAY_FIRST  = cfg[2][18:0]; // RULE_13
   assign WINDOW_DELAY_SECOND = cfg[3][18:0]; // RULE_13
   assign WINDOW_DELAY_THIRD  = cfg[4][18:0]; // RULE_13
   assign EDGE_MODE_CH1 = cfg[2][tdc_cfg_pkg::POS_EDGE1]; // RULE_14
   assign EDGE_MODE_CH2 = cfg[2][tdc_cfg_pkg::POS_EDGE2]; // RULE_14
   assign LONG_RANGE_TIMEOUT_SELECT = cfg[3][tdc_cfg_pkg::POS_TIMO +: 2]; // RULE_16
   assign FAST_INIT_ENABLE = cfg[3][tdc_cfg_pkg::POS_FAST]; // RULE_18
   assign PHASE_INVERT = cfg[5][15:0]; // RULE_19
   assign FIRE_REPEAT = cfg[5][tdc_cfg_pkg::POS_REPEAT +: 3]; // RULE_20
   assign PHASE_SHIFT_DISABLE = cfg[5][tdc_cfg_pkg::POS_NOPHASE]; // RULE_21
   assign START_NOISE_ENABLE = cfg[5][tdc_cfg_pkg::POS_SNOISE]; // RULE_21
   assign FIRE2_INVERT  = cfg[5][tdc_cfg_pkg::POS_PCONF]; // RULE_22
   assign FIRE2_DISABLE = cfg[5][tdc_cfg_pkg::POS_PCONF + 1]; // RULE_22
   assign FIRE1_DISABLE = cfg[5][tdc_cfg_pkg::POS_PCONF + 2]; // RULE_22

   // Enabled sources are ORed; the sources are same-clock levels.
   assign IRQ = |({TIMEOUT, HITS_DONE, ALU_DONE} &
                  cfg[2][tdc_cfg_pkg::POS_IRQ +: 3]); // RULE_15
   // A timeout asks the ALU to store all ones only when enabled.
   assign FORCE_ERR_VALUE = TIMEOUT &&
                            cfg[3][tdc_cfg_pkg::POS_ERRVAL]; // RULE_17

   // ************************************************************
   // Assertions.
   // ************************************************************
   bresp_after_write_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST) wr_fire |=> S_AXI_BVALID)
      else $error("write response missing"); // RULE_25
   cfg_stable_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST) !wr_fire |=> $stable(cfg[5]))
      else $error("register changed without write"); // RULE_25
   echo_byte_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST)
      (S_AXI_ARVALID && S_AXI_ARREADY &&
       S_AXI_ARADDR == tdc_cfg_pkg::ADDR_ECHO)
      |=> S_AXI_RDATA[7:0] == $past(cfg[1][23:16]))
      else $error("echo byte wrong"); // RULE_24
   reset_default_a: assert property (@(posedge CLK_SYS)
      SYS_RST |=> cfg[1] == tdc_cfg_pkg::RST_CFG1)
      else $error("reset default not loaded"); // RULE_23
   irq_gate_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST)
      (ALU_DONE && cfg[2][tdc_cfg_pkg::POS_IRQ]) |-> IRQ)
      else $error("enabled source gives no interrupt"); // RULE_15
   irq_quiet_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST)
      (cfg[2][23:21] == 3'h0) |-> !IRQ)
      else $error("masked interrupt raised"); // RULE_15
   err_force_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST)
      FORCE_ERR_VALUE |-> (TIMEOUT && cfg[3][21]))
      else $error("error value forced wrongly"); // RULE_17
   fire_div_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST)
      FIRE_DIVIDE == 5'(cfg[0][19:16]) + 5'h01)
      else $error("fire divide wrong"); // RULE_08
   prediv_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST)
      cfg[0][13] |-> FAST_CLOCK_PREDIVIDER == 3'h4)
      else $error("predivider wrong"); // RULE_06
   ch_disable_a: assert property (@(posedge CLK_SYS)
      disable iff (SYS_RST)
      CH1_ENABLE == (cfg[1][10:8] != 3'h0))
      else $error("channel enable wrong"); // RULE_10
endmodule // tdc_config_register_bank
`default_nettype wire

// *** tdc_cfg_pkg.sv ***
// Package of offsets, field positions, reset values and timing constants.
// How it works
// [RULE_01] Cycle clock select bit 6: 0 slow 32.768 kHz clock, 1 is 128 fast periods.
// [RULE_02] Bit 7 picks 2 or 7 discarded dummy temperature measurements.
// [RULE_03] Cycle time bit 8 picks 150 us or 300 us per temperature cycle.
// [RULE_04] Port count bit 9 picks two or four sensor ports.
// [RULE_05] Oscillator field 10-11: off, on, on after 640 us or 1280 us.
// [RULE_06] Predivider field 12-13 divides reference clock by 1, 2, 4, 4.
// [RULE_07] Calibration length field 14-15 picks 2, 4, 8 or 16 slow periods.
// [RULE_08] Fire divider 16-19 divides by value plus one; zero must not be written.
// [RULE_09] Pulse count 20-23 gives 1 to 15 pulses; zero switches generator off.
// [RULE_10] Expected hits fields: zero disables channel, 1-4 hits, 5-7 forbidden.
// [RULE_11] Short range result is operand a minus operand b by selector code.
// [RULE_12] Long range: host sets operand a to start code, b to 2-4.
// [RULE_13] Three 19-bit window delays, 14.5 fixed point in reference periods.
// [RULE_14] Edge bits 19, 20: 0 single edge, 1 both edges per channel.
// [RULE_15] Interrupt enables 21-23 gate sources, ORed onto one output.
// [RULE_16] Long range timeout field 19-20 picks 64 us to 4.096 ms.
// [RULE_17] Error value enable makes timeout write all ones as result.
// [RULE_18] Fourth register bit 22 enables fast init mode.
// [RULE_19] Phase bits 0-15 invert the matching pulse of the fire sequence.
// [RULE_20] Repetition field 16-18 repeats the fire sequence 0 to 7 more times.
// [RULE_21] Sixth register bit 19 disables phase noise, bit 20 adds start noise.
// [RULE_22] Bit 21 inverts fire output two, 22 disables it, 23 disables one.
// [RULE_23] Reset loads every field with its default value.
// [RULE_24] Upper 8 bits of second register are readable for link checking.
// [RULE_25] Fields drive static outputs, updated only when a write completes.
`default_nettype none
package tdc_cfg_pkg;
   // ************************************************************
   // Register map and widths.
   // ************************************************************
   localparam int          REG_COUNT    = 6;
   localparam int          REG_WIDTH    = 24;
   localparam logic [7:0]  ADDR_CFG0    = 8'h00;
   localparam logic [7:0]  ADDR_CFG1    = 8'h04;
   localparam logic [7:0]  ADDR_CFG2    = 8'h08;
   localparam logic [7:0]  ADDR_CFG3    = 8'h0C;
   localparam logic [7:0]  ADDR_CFG4    = 8'h10;
   localparam logic [7:0]  ADDR_CFG5    = 8'h14;
   localparam logic [7:0]  ADDR_ECHO    = 8'h18;
   // Reset values taken from the default column.
   localparam logic [23:0] RST_CFG0     = 24'h000668;
   localparam logic [23:0] RST_CFG1     = 24'h554000;
   localparam logic [23:0] RST_CFG2     = 24'h200000;
   localparam logic [23:0] RST_CFG3     = 24'h180000;
   localparam logic [23:0] RST_CFG4     = 24'h200000;
   localparam logic [23:0] RST_CFG5     = 24'h000000;
   // Bit positions of single flags and of the lowest bit of each field.
   localparam int          POS_CYC_CLK  = 6;
   localparam int          POS_DUMMY    = 7;
   localparam int          POS_CYC_TIME = 8;
   localparam int          POS_PORTS    = 9;
   localparam int          POS_OSC      = 10;
   localparam int          POS_PREDIV   = 12;
   localparam int          POS_CAL      = 14;
   localparam int          POS_FDIV     = 16;
   localparam int          POS_FCNT     = 20;
   localparam int          POS_HITS1    = 8;
   localparam int          POS_HITS2    = 11;
   localparam int          POS_OPA      = 16;
   localparam int          POS_OPB      = 20;
   localparam int          POS_EDGE1    = 19;
   localparam int          POS_EDGE2    = 20;
   localparam int          POS_IRQ      = 21;
   localparam int          POS_TIMO     = 19;
   localparam int          POS_ERRVAL   = 21;
   localparam int          POS_FAST     = 22;
   localparam int          POS_REPEAT   = 16;
   localparam int          POS_NOPHASE  = 19;
   localparam int          POS_SNOISE   = 20;
   localparam int          POS_PCONF    = 21;
   // ************************************************************
   // Timing constants at the documented 4 MHz fast clock.
   // ************************************************************
   localparam int          CYC_SHORT_US = 150;
   localparam int          CYC_LONG_US  = 300;
   localparam int          SETTLE_A_US  = 640;
   localparam int          SETTLE_B_US  = 1280;
   localparam int          FAST_CYC_PER = 128;
   localparam int          DUMMY_FEW    = 2;
   localparam int          DUMMY_MANY   = 7;
   localparam logic [1:0]  AXI_OKAY     = 2'h0;
   localparam logic [1:0]  AXI_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// *** tdc_cfg_decode.sv ***
// Decoder that turns raw fields into ready-to-use control values.
`default_nettype none
module tdc_cfg_decode (
   input  wire logic [23:0] cfg0,
   input  wire logic [23:0] cfg3,
   output logic      [2:0]  dummy_count,
   output logic      [8:0]  cycle_time_us,
   output logic      [2:0]  prediv_factor,
   output logic      [4:0]  cal_periods,
   output logic      [4:0]  fire_divide,
   output logic      [10:0] settle_us,
   output logic             osc_enable,
   output logic      [7:0]  cycle_clk_fast_periods
);
   // ************************************************************
   // Decoding of field codes.
   // ************************************************************
   // Each decode is a pure table, so software sees the effect at once.
   always_comb begin
      dummy_count = cfg0[tdc_cfg_pkg::POS_DUMMY] ?
         3'(tdc_cfg_pkg::DUMMY_MANY) : 3'(tdc_cfg_pkg::DUMMY_FEW); // RULE_02
      cycle_time_us = cfg0[tdc_cfg_pkg::POS_CYC_TIME] ?
         9'(tdc_cfg_pkg::CYC_LONG_US) :
         9'(tdc_cfg_pkg::CYC_SHORT_US); // RULE_03
      // A zero period count means the slow crystal clock is used.
      cycle_clk_fast_periods = cfg0[tdc_cfg_pkg::POS_CYC_CLK] ?
         8'(tdc_cfg_pkg::FAST_CYC_PER) : 8'h00; // RULE_01
      unique case (cfg0[tdc_cfg_pkg::POS_PREDIV +: 2]) // RULE_06
         2'h0: prediv_factor = 3'h1;
         2'h1: prediv_factor = 3'h2;
         default: prediv_factor = 3'h4;
      endcase
      cal_periods = 5'(5'h02 << cfg0[tdc_cfg_pkg::POS_CAL +: 2]); // RULE_07
      // Code zero is forbidden; it decodes to one so nothing divides by 0.
      fire_divide = 5'(cfg0[tdc_cfg_pkg::POS_FDIV +: 4]) + 5'h01; // RULE_08
      osc_enable = cfg0[tdc_cfg_pkg::POS_OSC +: 2] != 2'h0; // RULE_05
      unique case (cfg0[tdc_cfg_pkg::POS_OSC +: 2]) // RULE_05
         2'h2: settle_us = 11'(tdc_cfg_pkg::SETTLE_A_US);
         2'h3: settle_us = 11'(tdc_cfg_pkg::SETTLE_B_US);
         default: settle_us = 11'h000;
      endcase
   end
   // The timeout field is passed raw by the top; unused here.
   logic unused_cfg3;
   assign unused_cfg3 = ^cfg3;
endmodule // tdc_cfg_decode
`default_nettype wire

// *** tdc_src_model.sv ***
// Model of the measurement units that raise the event sources.
`default_nettype none
module tdc_src_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] cmd,
   output logic            alu_done,
   output logic            hits_done,
   output logic            timeout
);
   timeunit 1ns;
   timeprecision 1ns;
   // Sources follow the command one clock late, as a real unit would.
   always_ff @(posedge clk) begin
      if (rst) begin
         {timeout, hits_done, alu_done} <= 3'h0;
      end else begin
         {timeout, hits_done, alu_done} <= cmd;
      end
   end
endmodule // tdc_src_model
`default_nettype wire

// *** tdc_config_register_bank_tb_top.sv ***
// Self-checking bench for the configuration register bank.
`default_nettype none
module tdc_config_register_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        CLK_SYS, SYS_RST, IRQ, FORCE_ERR_VALUE, ALU_DONE;
   logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   logic        S_AXI_RVALID, S_AXI_RREADY, HITS_DONE, TIMEOUT;
   logic        TEMP_CYCLE_CLOCK_SELECT, TEMP_FOUR_PORTS, FAST_OSC_ENABLE;
   logic        FIRE_ENABLE, CH1_ENABLE, CH2_ENABLE, EDGE_MODE_CH1;
   logic        EDGE_MODE_CH2, FAST_INIT_ENABLE, PHASE_SHIFT_DISABLE;
   logic        START_NOISE_ENABLE, FIRE1_DISABLE, FIRE2_DISABLE;
   logic        FIRE2_INVERT;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, LONG_RANGE_TIMEOUT_SELECT;
   logic [2:0]  DUMMY_COUNT, FAST_CLOCK_PREDIVIDER, EXPECTED_HITS_CH1;
   logic [2:0]  EXPECTED_HITS_CH2, FIRE_REPEAT, src_cmd;
   logic [3:0]  S_AXI_WSTRB, PULSE_COUNT, ALU_OPERAND_A, ALU_OPERAND_B;
   logic [4:0]  RESONATOR_CAL_LENGTH, FIRE_DIVIDE;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, CYCLE_CLK_FAST_PERIODS;
   logic [8:0]  TEMP_CYCLE_TIME_US;
   logic [10:0] FAST_OSC_SETTLE_US;
   logic [15:0] PHASE_INVERT;
   logic [18:0] WINDOW_DELAY_FIRST, WINDOW_DELAY_SECOND;
   logic [18:0] WINDOW_DELAY_THIRD;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   int          fail_count, checks_done, cycles;
   tdc_config_register_bank uut (.*);
   tdc_src_model src (.clk(CLK_SYS), .rst(SYS_RST), .cmd(src_cmd),
      .alu_done(ALU_DONE), .hits_done(HITS_DONE), .timeout(TIMEOUT));
   // Clock at 25 MHz.
   always #20 CLK_SYS = ~CLK_SYS;
   // Hang guard: the whole run needs well under a thousand cycles.
   always @(posedge CLK_SYS) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d.", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus write; a fresh edge first so no strobe is driven twice a step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      @(posedge CLK_SYS);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge CLK_SYS);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 1'b0;
      chk(S_AXI_BRESP, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      @(posedge CLK_SYS);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLK_SYS);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      S_AXI_RREADY <= 1'b0;
      chk(S_AXI_RDATA, ed);
      chk(S_AXI_RRESP, er);
   endtask
   // Every field must show its power-on value.
   task automatic t_defaults();
      chk({TEMP_CYCLE_CLOCK_SELECT, CYCLE_CLK_FAST_PERIODS, DUMMY_COUNT,
         TEMP_CYCLE_TIME_US, TEMP_FOUR_PORTS},
         {1'b1, 8'd128, 3'd2, 9'd150, 1'b1});
      chk({FAST_OSC_ENABLE, FAST_OSC_SETTLE_US, FAST_CLOCK_PREDIVIDER,
         RESONATOR_CAL_LENGTH, FIRE_DIVIDE, PULSE_COUNT, FIRE_ENABLE},
         {1'b1, 11'd0, 3'd1, 5'd2, 5'd1, 4'd0, 1'b0});
      chk({ALU_OPERAND_A, ALU_OPERAND_B, EXPECTED_HITS_CH1, EXPECTED_HITS_CH2,
         CH1_ENABLE, CH2_ENABLE, LONG_RANGE_TIMEOUT_SELECT, FAST_INIT_ENABLE},
         {8'h55, 6'd0, 2'd0, 2'd3, 1'b0});
      chk({WINDOW_DELAY_FIRST, EDGE_MODE_CH1, EDGE_MODE_CH2}, 0);
      chk(WINDOW_DELAY_SECOND, 0);
      chk(WINDOW_DELAY_THIRD, 0);
      chk({PHASE_INVERT, FIRE_REPEAT, PHASE_SHIFT_DISABLE, START_NOISE_ENABLE,
         FIRE1_DISABLE, FIRE2_DISABLE, FIRE2_INVERT}, 0);
      rd(tdc_cfg_pkg::ADDR_ECHO, 32'h55, tdc_cfg_pkg::AXI_OKAY);
   endtask
   // Every code of the clock and oscillator fields and four codes of each fire field, in turn.
   task automatic t_cfg0();
      int s [4] = '{0, 0, 640, 1280};
      int p [4] = '{1, 2, 4, 4};
      for (int i = 0; i < 4; i++) begin
         wr(tdc_cfg_pkg::ADDR_CFG0, (i * 5 << 20) | (15 - i * 4 << 16) |
            (i << 14) | (i << 12) | (i << 10) | (i << 8) | (i << 6), 4'hF,
            tdc_cfg_pkg::AXI_OKAY);
         chk({TEMP_CYCLE_CLOCK_SELECT, CYCLE_CLK_FAST_PERIODS, DUMMY_COUNT,
            TEMP_CYCLE_TIME_US, TEMP_FOUR_PORTS}, {i[0], 8'(i[0] ? 128 : 0),
            3'(i[1] ? 7 : 2), 9'(i[0] ? 300 : 150), i[1]});
         chk({FAST_OSC_ENABLE, FAST_OSC_SETTLE_US, FAST_CLOCK_PREDIVIDER,
            RESONATOR_CAL_LENGTH}, {i != 0, 11'(s[i]), 3'(p[i]),
            5'(2 << i)});
         chk({FIRE_DIVIDE, PULSE_COUNT, FIRE_ENABLE},
            {5'(16 - i * 4), 4'(i * 5), i != 0});
      end
   endtask
   // Every operand selector code, hit counts and the readable echo.
   task automatic t_cfg1();
      for (int k = 0; k < 13; k++) begin
         wr(tdc_cfg_pkg::ADDR_CFG1, (12 - k << 20) | (k << 16) |
            (4 - k % 5 << 11) | (k % 5 << 8), 4'hF,
            tdc_cfg_pkg::AXI_OKAY);
         chk({ALU_OPERAND_A, ALU_OPERAND_B, EXPECTED_HITS_CH1,
            EXPECTED_HITS_CH2, CH1_ENABLE, CH2_ENABLE}, {4'(k), 4'(12 - k),
            3'(k % 5), 3'(4 - k % 5), k % 5 != 0, k % 5 != 4});
         rd(tdc_cfg_pkg::ADDR_ECHO, {4'(12 - k), 4'(k)},
            tdc_cfg_pkg::AXI_OKAY);
      end
      // Long range pairing: start code against the first stop.
      wr(tdc_cfg_pkg::ADDR_CFG1, 32'h0021_0000, 4'hF,
         tdc_cfg_pkg::AXI_OKAY);
      chk({ALU_OPERAND_A, ALU_OPERAND_B}, 8'h12);
   endtask
   // All three window delays, the first and third from their top, edge, timeout and fire shaping codes.
   task automatic t_windows();
      for (int j = 0; j < 4; j++) begin
         wr(tdc_cfg_pkg::ADDR_CFG2, (j << 19) | (32'h7FFFF >> j), 4'hF,
            tdc_cfg_pkg::AXI_OKAY);
         wr(tdc_cfg_pkg::ADDR_CFG3, (j << 19) | (j << 21) | j * 32'h1111,
            4'hF, tdc_cfg_pkg::AXI_OKAY);
         wr(tdc_cfg_pkg::ADDR_CFG4, 32'h7FFFF - j, 4'hF,
            tdc_cfg_pkg::AXI_OKAY);
         wr(tdc_cfg_pkg::ADDR_CFG5, (7 - j << 21) | (j << 19) |
            (7 - 2 * j << 16) | (1 << j * 5), 4'hF,
            tdc_cfg_pkg::AXI_OKAY);
         chk({WINDOW_DELAY_FIRST, EDGE_MODE_CH1, EDGE_MODE_CH2},
            {19'h7FFFF >> j, j[0], j[1]});
         chk({LONG_RANGE_TIMEOUT_SELECT, FAST_INIT_ENABLE, WINDOW_DELAY_SECOND},
            {j[1:0], j[1], 19'(j * 32'h1111)});
         chk(WINDOW_DELAY_THIRD, 32'h7FFFF - j);
         chk({PHASE_INVERT, FIRE_REPEAT, PHASE_SHIFT_DISABLE,
            START_NOISE_ENABLE, FIRE1_DISABLE, FIRE2_DISABLE, FIRE2_INVERT},
            {16'h1 << j * 5, 3'(7 - 2 * j), j[0], j[1],
            3'(7 - j)});
      end
      // Lane strobes, the dropped top byte and refused places.
      wr(tdc_cfg_pkg::ADDR_CFG4, 32'hFF00_0000, 4'h9, tdc_cfg_pkg::AXI_OKAY);
      chk(WINDOW_DELAY_THIRD, 32'h7FF00);
      wr(8'h1C, 32'h0, 4'hF, tdc_cfg_pkg::AXI_SLVERR);
      chk(WINDOW_DELAY_THIRD, 32'h7FF00);
      rd(tdc_cfg_pkg::ADDR_CFG0, 32'h0, tdc_cfg_pkg::AXI_SLVERR);
   endtask
   // Every mask against every source pattern.
   task automatic t_irq();
      for (int m = 0; m < 8; m++) begin
         wr(tdc_cfg_pkg::ADDR_CFG2, m << 21, 4'hF, tdc_cfg_pkg::AXI_OKAY);
         wr(tdc_cfg_pkg::ADDR_CFG3, m << 21, 4'hF, tdc_cfg_pkg::AXI_OKAY);
         for (int s = 0; s < 8; s++) begin
            src_cmd <= 3'(s);
            repeat (2) @(posedge CLK_SYS);
            chk({IRQ, FORCE_ERR_VALUE},
               {|(m & s), s[2] & m[0]});
         end
         src_cmd <= 3'h0;
      end
   endtask
   initial begin
      {CLK_SYS, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 4'h0;
      {S_AXI_ARVALID, S_AXI_RREADY, src_cmd, S_AXI_WSTRB} = 9'h0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
      {fail_count, checks_done, cycles} = {32'h0, 32'h0, 32'h0};
      SYS_RST = 1'b1;
      repeat (12) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      t_defaults();
      t_cfg0();
      t_cfg1();
      t_windows();
      t_irq();
      // A second reset in mid-run must bring back every default.
      @(posedge CLK_SYS);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      t_defaults();
      wrap_up();
   end
endmodule // tdc_config_register_bank_tb_top
`default_nettype wire
